// ==== inc/asr_map.svh ====
// Constants of the asynchronous serial receiver: counts, positions and reset values.
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

`define ASR_OVERSAMPLE     16
`define ASR_CNT_W          4
`define ASR_CNT_EDGE       4'h1
`define ASR_CNT_RST        4'h0
`define ASR_MID_FIRST      4'h7
`define ASR_MID_LAST       4'h9
`define ASR_BITS_8         4'h8
`define ASR_BITS_9         4'h9
`define ASR_BITS_RST       4'h0
`define ASR_DATA_W         9
`define ASR_DATA_RST       9'h000
`define ASR_SAMPLES_RST    3'h7
`define ASR_SYNC_RST       2'h3
`define ASR_FIFO_DEPTH     2

`endif

// ==== inc/asr_pkg.sv ====
// Types shared by the asynchronous serial receiver files.
`include "asr_map.svh"

package asr_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } asr_state_e;

    typedef struct packed {
        logic continuous_receive_enable;
        logic sync_mode_select;
        logic serial_port_enable;
        logic receive_polarity_invert;
        logic nine_bit_mode;
    } asr_ctrl_s;

    typedef struct packed {
        logic                    framing_error;
        logic [`ASR_DATA_W-1:0]  data;
    } asr_char_s;

    typedef struct packed {
        logic [1:0]              line_sync;
        logic                    prev_line;
        logic [`ASR_CNT_W-1:0]   tick_cnt;
        logic [`ASR_CNT_W-1:0]   bit_cnt;
        logic [2:0]              samples;
        logic [`ASR_DATA_W-1:0]  receive_shift_reg;
        logic                    overrun;
        asr_state_e              state;
    } asr_rx_st_s;

endpackage

// ==== rtl/asr_fifo.sv ====
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/10ps
module asr_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0] rptr;
        logic [PW-1:0] wptr;
        logic [CW-1:0] count;
    } asr_fifo_st_s;

    asr_fifo_st_s           q;
    asr_fifo_st_s           d;
    logic [WIDTH-1:0]       mem [DEPTH];
    logic                   push;
    logic                   pop;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1)) begin
            return '0;
        end
        return p + PW'(1);
    endfunction

    assign in_ready  = (q.count != CW'(DEPTH));
    assign out_valid = (q.count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[q.rptr];

    always_comb begin
        d = q;
        if (push) begin
            d.wptr = next_ptr(q.wptr);
        end
        if (pop) begin
            d.rptr = next_ptr(q.rptr);
        end
        if (push && !pop) begin
            d.count = q.count + CW'(1);
        end else if (pop && !push) begin
            d.count = q.count - CW'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // The storage holds no control state, so it needs no reset.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[q.wptr] <= in_data;
        end
    end
endmodule

// ==== rtl/asr_top.sv ====
// Asynchronous serial receiver: start detection, oversampled bit recovery and character FIFO.
//
// What this block does
// RULE_01 - Line oversampled sixteen times, shifter per bit.
// RULE_02 - Finished eight or nine bit character enters FIFO.
// RULE_03 - Two characters buffered while a third shifts.
// RULE_04 - Characters reachable only through receive data register.
// RULE_05 - Reception needs receive enable, async mode, port enable.
// RULE_06 - Falling edge starts character; start bit is zero.
// RULE_07 - Half bit check; high start aborts silently.
// RULE_08 - Each data bit majority sampled at centre.
// RULE_09 - Stop bit sampled; zero sets framing error.
// RULE_10 - After stop, push character and raise flag.
// RULE_11 - Reading data register pops oldest character.
// RULE_12 - Polarity invert makes idle and data low-true.
// RULE_13 - Polarity invert acts only in asynchronous mode.
// RULE_14 - Full FIFO on completion sets sticky overrun.
// RULE_15 - Receive flag stays while FIFO holds characters.
`timescale 1ns/10ps
`include "asr_map.svh"
module asr_top
    import asr_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire logic      receive_line,
    input  wire logic      baud_x16_tick,
    input  wire asr_ctrl_s ctrl,
    input  wire logic      overrun_clear,
    input  wire logic      receive_data_read,
    output asr_char_s      receive_data_reg,
    output logic           receive_interrupt_flag,
    output logic           overrun_error,
    output logic           receiver_busy
);
    asr_rx_st_s             q;
    asr_rx_st_s             d;
    logic                   rx_enable;
    logic                   line;
    logic                   in_window;
    logic                   decide;
    logic                   vote;
    logic [`ASR_CNT_W-1:0]  bits_needed;
    logic                   push_valid;
    logic                   push_ready;
    asr_char_s              push_char;
    logic                   fifo_valid;

    // Majority of the two earlier centre samples and the present one.
    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Eight-bit characters sit in the upper bits after an LSB-first shift, so
    // they are moved down to the low end on the way into the FIFO.
    function automatic logic [`ASR_DATA_W-1:0] align_char(
        input logic [`ASR_DATA_W-1:0] sr,
        input logic                   nine
    );
        if (nine) begin
            return sr;
        end
        return {1'b0, sr[`ASR_DATA_W-1:1]};
    endfunction

    assign rx_enable   = ctrl.continuous_receive_enable & ~ctrl.sync_mode_select
                         & ctrl.serial_port_enable; // RULE_05
    assign line        = q.line_sync[1] ^ (ctrl.receive_polarity_invert
                         & ~ctrl.sync_mode_select); // RULE_12 RULE_13
    assign in_window   = (q.tick_cnt >= `ASR_MID_FIRST) && (q.tick_cnt <= `ASR_MID_LAST);
    assign decide      = baud_x16_tick && (q.tick_cnt == `ASR_MID_LAST);
    assign vote        = maj3({q.samples[1:0], line}); // RULE_08
    assign bits_needed = ctrl.nine_bit_mode ? `ASR_BITS_9 : `ASR_BITS_8; // RULE_02

    always_comb begin
        d          = q;
        push_valid = 1'b0;
        push_char  = '0;
        // Only the second stage is looked at; the first one may be metastable.
        d.line_sync = {q.line_sync[0], receive_line};
        if (baud_x16_tick) begin
            d.prev_line = line;
            d.tick_cnt  = q.tick_cnt + `ASR_CNT_EDGE; // RULE_01
            if (in_window) begin
                d.samples = {q.samples[1:0], line};
            end
        end
        case (q.state)
            ST_IDLE: begin
                if (baud_x16_tick && q.prev_line && !line && !q.overrun) begin
                    d.state    = ST_START; // RULE_06
                    d.tick_cnt = `ASR_CNT_EDGE;
                    d.samples  = `ASR_SAMPLES_RST;
                end
            end
            ST_START: begin
                if (decide) begin
                    if (!vote) begin
                        d.state   = ST_DATA;
                        d.bit_cnt = `ASR_BITS_RST;
                    end else begin
                        d.state = ST_IDLE; // RULE_07
                    end
                end
            end
            ST_DATA: begin
                // The counter wraps after sixteen ticks, so the next decision falls
                // one full bit time later without reloading it.
                if (decide) begin
                    d.receive_shift_reg = {vote, q.receive_shift_reg[`ASR_DATA_W-1:1]};
                    d.bit_cnt           = q.bit_cnt + `ASR_CNT_EDGE; // RULE_08
                    if (q.bit_cnt + `ASR_CNT_EDGE == bits_needed) begin
                        d.state = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                if (decide) begin
                    push_valid              = 1'b1; // RULE_10 RULE_02
                    push_char.framing_error = ~vote; // RULE_09
                    push_char.data          = align_char(q.receive_shift_reg,
                                                         ctrl.nine_bit_mode);
                    d.state                 = ST_IDLE;
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase
        if (!rx_enable) begin
            d.state = ST_IDLE;
        end
        // Clearing receive enable also clears overrun, as does the explicit clear.
        if (overrun_clear || !ctrl.continuous_receive_enable) begin
            d.overrun = 1'b0;
        end
        // A character lost in the clearing cycle still raises overrun.
        if (push_valid && !push_ready) begin
            d.overrun = 1'b1; // RULE_14
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q.line_sync         <= `ASR_SYNC_RST;
            q.prev_line         <= 1'b1;
            q.tick_cnt          <= `ASR_CNT_RST;
            q.bit_cnt           <= `ASR_BITS_RST;
            q.samples           <= `ASR_SAMPLES_RST;
            q.receive_shift_reg <= `ASR_DATA_RST;
            q.overrun           <= 1'b0;
            q.state             <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // The shift register keeps working while the FIFO is full, which gives
    // room for a third character before software must act.
    asr_fifo #(
        .WIDTH ($bits(asr_char_s)),
        .DEPTH (`ASR_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_char),
        .out_valid (fifo_valid),
        .out_ready (receive_data_read), // RULE_11 RULE_04
        .out_data  (receive_data_reg)
    ); // RULE_03

    assign receive_interrupt_flag = fifo_valid; // RULE_15
    assign overrun_error          = q.overrun;
    assign receiver_busy          = (q.state != ST_IDLE);

    AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
        !rx_enable |=> (q.state == ST_IDLE))
        else $error("Receiver active while disabled.");

    AST_START_ON_FALL: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
        (q.state == ST_IDLE) ##1 (q.state == ST_START) |-> $past(q.prev_line) && !$past(line))
        else $error("Start entered without a falling edge.");

    AST_FALSE_START: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
        (q.state == ST_START) && decide && vote && rx_enable
        |-> !push_valid ##1 (q.state == ST_IDLE) && $stable(q.overrun))
        else $error("False start not dropped silently.");

    AST_HALF_BIT: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
        (q.state == ST_START) && decide |-> (q.tick_cnt == `ASR_MID_LAST) && baud_x16_tick)
        else $error("Start check off its half bit point.");

    AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        (q.state == ST_DATA) && decide && rx_enable
        |=> q.receive_shift_reg[8] == $past(vote)
        && q.bit_cnt == $past(q.bit_cnt) + `ASR_CNT_EDGE)
        else $error("Data bit not shifted in.");

    AST_BIT_COUNT: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
        $rose(q.state == ST_STOP) |-> (q.bit_cnt == bits_needed))
        else $error("Wrong number of data bits before stop.");

    AST_FRAMING: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
        push_valid |-> (push_char.framing_error == !vote) && (q.state == ST_STOP))
        else $error("Framing error does not follow stop sample.");

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
        push_valid && push_ready |=> receive_interrupt_flag)
        else $error("Receive flag not set after a stored character.");

    AST_OVERRUN: assert property (@(posedge clk) disable iff (!resetn) // RULE_14
        push_valid && !push_ready |=> overrun_error ##1 (overrun_error
        || $past(overrun_clear) || !$past(ctrl.continuous_receive_enable)))
        else $error("Overrun not raised or not held.");

    AST_OVR_NO_START: assert property (@(posedge clk) disable iff (!resetn) // RULE_14
        q.overrun && (q.state == ST_IDLE) |=> (q.state == ST_IDLE))
        else $error("Reception resumed during overrun.");

    AST_FLAG_LAST_READ: assert property (@(posedge clk) disable iff (!resetn) // RULE_15
        receive_interrupt_flag && receive_data_read && !push_valid
        ##1 receive_interrupt_flag && receive_data_read && !push_valid
        |=> !receive_interrupt_flag)
        else $error("Receive flag left set after two-entry FIFO drained.");

    AST_TICK_STILL: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
        !baud_x16_tick
        |=> $stable(q.tick_cnt))
        else $error("Bit timing moved without a tick.");

    AST_TICK_STEP: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
        baud_x16_tick && (q.state != ST_IDLE)
        |=> (q.tick_cnt == $past(q.tick_cnt) + `ASR_CNT_EDGE))
        else $error("Bit timing skipped a tick.");

    AST_START_LOAD: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
        $rose(q.state == ST_START)
        |-> (q.tick_cnt == `ASR_CNT_EDGE) && (q.samples == `ASR_SAMPLES_RST))
        else $error("Start check not timed from the edge.");

    AST_START_WAIT: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
        (q.state == ST_START) && !decide && rx_enable
        |=> (q.state == ST_START))
        else $error("Start bit left before its centre.");

    AST_START_TO_DATA: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        (q.state == ST_START) && decide && !vote && rx_enable
        |=> (q.state == ST_DATA) && (q.bit_cnt == `ASR_BITS_RST))
        else $error("Valid start bit not followed by data.");

    AST_DATA_WAIT: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        (q.state == ST_DATA) && !decide && rx_enable
        |=> (q.state == ST_DATA) && $stable(q.receive_shift_reg))
        else $error("Data bit taken away from its centre.");

    AST_DATA_TO_STOP: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
        (q.state == ST_DATA) && decide && rx_enable
        && (q.bit_cnt == bits_needed - `ASR_CNT_EDGE)
        |=> (q.state == ST_STOP))
        else $error("Stop bit not awaited after the last data bit.");

    AST_STOP_WAIT: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
        (q.state == ST_STOP) && !decide && rx_enable
        |=> (q.state == ST_STOP))
        else $error("Stop bit left before its centre.");

    AST_STOP_TO_IDLE: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
        (q.state == ST_STOP) && decide
        |=> (q.state == ST_IDLE))
        else $error("Receiver not idle after the stop bit.");

    AST_PUSH_AT_STOP: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
        push_valid
        |-> (q.state == ST_STOP) && decide)
        else $error("Character stored away from the stop centre.");

    AST_ONE_PUSH: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
        push_valid
        |=> !push_valid)
        else $error("One character stored twice.");

    AST_ALIGN_8: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
        push_valid && !ctrl.nine_bit_mode
        |-> (push_char.data == {1'b0, q.receive_shift_reg[8:1]}))
        else $error("Eight-bit character not aligned low.");

    AST_ALIGN_9: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
        push_valid && ctrl.nine_bit_mode
        |-> (push_char.data == q.receive_shift_reg))
        else $error("Nine-bit character altered on storing.");

    AST_DISABLED_NO_PUSH: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
        !rx_enable
        |=> !push_valid)
        else $error("Character stored while disabled.");

    AST_IDLE_NEEDS_TICK: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
        (q.state == ST_IDLE) && !baud_x16_tick
        |=> (q.state == ST_IDLE))
        else $error("Start taken between ticks.");

    AST_IDLE_NO_EDGE: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
        (q.state == ST_IDLE) && !(q.prev_line && !line)
        |=> (q.state == ST_IDLE))
        else $error("Start taken without a falling edge.");

    AST_THIRD_START: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
        (q.state == ST_IDLE) && !push_ready && !q.overrun && rx_enable && baud_x16_tick
        && q.prev_line && !line
        |=> (q.state == ST_START))
        else $error("Third character not started while buffer full.");

    AST_POL_TRUE: assert property (@(posedge clk) disable iff (!resetn) // RULE_12
        !ctrl.receive_polarity_invert
        |-> (line == q.line_sync[1]))
        else $error("Line inverted without the polarity control.");

    AST_POL_INVERT: assert property (@(posedge clk) disable iff (!resetn) // RULE_12
        ctrl.receive_polarity_invert && !ctrl.sync_mode_select
        |-> (line != q.line_sync[1]))
        else $error("Polarity control did not invert the line.");

    AST_POL_SYNC: assert property (@(posedge clk) disable iff (!resetn) // RULE_13
        ctrl.sync_mode_select
        |-> (line == q.line_sync[1]))
        else $error("Polarity control acted in synchronous mode.");

    AST_OVR_HOLD: assert property (@(posedge clk) disable iff (!resetn) // RULE_14
        q.overrun && !overrun_clear && ctrl.continuous_receive_enable
        |=> q.overrun)
        else $error("Overrun dropped without a clear.");

    AST_OVR_ONLY_LOSS: assert property (@(posedge clk) disable iff (!resetn) // RULE_14
        !q.overrun && !(push_valid && !push_ready)
        |=> !q.overrun)
        else $error("Overrun raised without a lost character.");

    AST_OVR_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // RULE_14
        overrun_clear && !(push_valid && !push_ready)
        |=> !q.overrun)
        else $error("Overrun survived its clear.");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!resetn) // RULE_15
        receive_interrupt_flag && !receive_data_read
        |=> receive_interrupt_flag)
        else $error("Receive flag dropped without a read.");

    AST_FLAG_NEEDS_PUSH: assert property (@(posedge clk) disable iff (!resetn) // RULE_15
        !receive_interrupt_flag && !push_valid
        |=> !receive_interrupt_flag)
        else $error("Receive flag raised without a character.");

    AST_HEAD_STABLE: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
        receive_interrupt_flag && !receive_data_read
        |=> $stable(receive_data_reg))
        else $error("Oldest character changed without a read.");
endmodule

// ==== verification/asr_tx_model.sv ====
// Remote asynchronous transmitter model that drives the receive line, timed by the x16 tick.
`timescale 1ns/10ps
module asr_tx_model (
    input  wire logic clk,
    input  wire logic tick,
    input  wire logic inv,
    output logic      line
);
    // The line idles at the level of a pull-up until the first frame.
    initial line = 1'b1;

    // Drive one level for a number of ticks; polarity follows the inversion control.
    task automatic hold_bit(input logic b, input int n);
        line <= b ^ inv;
        repeat (n) @(posedge clk iff tick === 1'b1);
    endtask

    // Start bit low, data bits least significant first, then the requested stop level.
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        hold_bit(1'b0, 16);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            hold_bit(d[i], 16);
        end
        hold_bit(stop, 16);
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking testbench of the asynchronous serial receiver with a remote transmitter model.
`timescale 1ns/10ps
module testbench
    import asr_pkg::*;
;
    logic      clk = 1'b0;
    logic      resetn = 1'b0;
    logic      receive_line;
    logic      baud_x16_tick = 1'b0;
    asr_ctrl_s ctrl = 5'h00;
    logic      overrun_clear = 1'b0;
    logic      receive_data_read = 1'b0;
    asr_char_s receive_data_reg;
    logic      receive_interrupt_flag;
    logic      overrun_error;
    logic      receiver_busy;
    logic [1:0] tick_div_q = 2'h0;
    int        failures = 0;
    int        samples_checked = 0;

    always #10 clk = ~clk;

    // A tick every fourth clock keeps a bit at 64 clocks and the run short.
    always @(posedge clk) begin
        tick_div_q <= tick_div_q + 2'h1;
        baud_x16_tick <= (tick_div_q == 2'h3);
    end

    asr_top u_dut (
        .clk                    (clk),
        .resetn                 (resetn),
        .receive_line           (receive_line),
        .baud_x16_tick          (baud_x16_tick),
        .ctrl                   (ctrl),
        .overrun_clear          (overrun_clear),
        .receive_data_read      (receive_data_read),
        .receive_data_reg       (receive_data_reg),
        .receive_interrupt_flag (receive_interrupt_flag),
        .overrun_error          (overrun_error),
        .receiver_busy          (receiver_busy)
    );

    asr_tx_model u_tx (
        .clk  (clk),
        .tick (baud_x16_tick),
        .inv  (ctrl.receive_polarity_invert),
        .line (receive_line)
    );

    task automatic complete_run;
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Flags are sampled at the falling edge so every update of the rising edge has landed.
    task automatic status(input logic flag, input logic ovr, input logic busy);
        logic [2:0] seen;
        @(negedge clk);
        seen = {receive_interrupt_flag, overrun_error, receiver_busy};
        check({7'h00, seen}, {7'h00, flag, ovr, busy});
    endtask

    task automatic pop(input logic [9:0] exp);
        @(negedge clk);
        check({9'h000, receive_interrupt_flag}, 10'h001);
        check(receive_data_reg, exp);
        @(posedge clk);
        receive_data_read <= 1'b1;
        @(posedge clk);
        receive_data_read <= 1'b0;
    endtask

    // Reads on two edges in a row; the second entry must be at the head in between.
    task automatic pop_two(input logic [9:0] exp_a, input logic [9:0] exp_b);
        @(negedge clk);
        check({9'h000, receive_interrupt_flag}, 10'h001);
        check(receive_data_reg, exp_a);
        @(posedge clk);
        receive_data_read <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check({9'h000, receive_interrupt_flag}, 10'h001);
        check(receive_data_reg, exp_b);
        @(posedge clk);
        receive_data_read <= 1'b0;
    endtask

    task automatic set_ctrl(input logic [4:0] c);
        @(posedge clk);
        ctrl <= c;
        @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        status(1'b0, 1'b0, 1'b0);
        set_ctrl(5'h14);
        u_tx.hold_bit(1'b1, 4);
        u_tx.send(9'h0A5, 1'b0, 1'b1);
        status(1'b1, 1'b0, 1'b0);
        pop(10'h0A5);
        status(1'b0, 1'b0, 1'b0);
        set_ctrl(5'h15);
        u_tx.send(9'h1C3, 1'b1, 1'b1);
        pop(10'h1C3);
        set_ctrl(5'h14);
        u_tx.send(9'h03C, 1'b0, 1'b0);
        u_tx.hold_bit(1'b1, 4);
        pop(10'h23C);
        // A low pulse shorter than half a bit must be dropped without any trace.
        u_tx.hold_bit(1'b0, 4);
        status(1'b0, 1'b0, 1'b1);
        u_tx.hold_bit(1'b1, 16);
        status(1'b0, 1'b0, 1'b0);
        // Four frames back to back: two are kept, the third overruns the buffer, the fourth is not received.
        u_tx.send(9'h011, 1'b0, 1'b1);
        u_tx.send(9'h022, 1'b0, 1'b1);
        status(1'b1, 1'b0, 1'b0);
        u_tx.send(9'h033, 1'b0, 1'b1);
        status(1'b1, 1'b1, 1'b0);
        u_tx.send(9'h044, 1'b0, 1'b1);
        pop_two(10'h011, 10'h022);
        status(1'b0, 1'b1, 1'b0);
        @(posedge clk);
        overrun_clear <= 1'b1;
        @(posedge clk);
        overrun_clear <= 1'b0;
        status(1'b0, 1'b0, 1'b0);
        u_tx.send(9'h055, 1'b0, 1'b1);
        pop(10'h055);
        // Each of the three enables turned the wrong way must block reception.
        for (int i = 0; i < 3; i++) begin
            set_ctrl(i == 0 ? 5'h04 : (i == 1 ? 5'h1C : 5'h10));
            u_tx.send(9'h066, 1'b0, 1'b1);
            status(1'b0, 1'b0, 1'b0);
        end
        // Polarity is switched with the receiver off so the idle change is no start edge.
        set_ctrl(5'h06);
        u_tx.hold_bit(1'b1, 4);
        set_ctrl(5'h16);
        u_tx.send(9'h05A, 1'b0, 1'b1);
        pop(10'h05A);
        status(1'b0, 1'b0, 1'b0);
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule
